// >>> src/bbc_pkg.sv
// Package: register map, field positions, modes and timing for brightness control
package bbc_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BOOST_CONFIG = 8'h13;
   localparam logic [7:0] OFS_BRIGHT_MODE = 8'h11;
   localparam logic [7:0] OFS_RAMP_CONFIG = 8'h12;
   localparam logic [7:0] OFS_AUTO_HIGH = 8'h15;
   localparam logic [7:0] OFS_AUTO_LOW = 8'h16;
   localparam logic [7:0] OFS_BRIGHT_LOW = 8'h18;
   localparam logic [7:0] OFS_BRIGHT_HIGH = 8'h19;
   localparam logic [7:0] OFS_STATUS = 8'h1A;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_FREQ_SEL = 5;
   localparam int BIT_FREQ_SHIFT = 6;
   localparam int BIT_MIN_IND = 4;
   localparam logic [7:0] RST_BOOST_CONFIG = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'h00;
   localparam logic [7:0] RST_BRIGHT = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_RAMP = 8'h00;
   localparam int CODE_W = 11;
   localparam logic [10:0] CODE_MAX = 11'h7FF;
   // ------------------------------------------------------------
   // Timing: ramp step base time and PWM measurement window length
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int RAMP_BASE_US = 1000;
   localparam int RAMP_BASE_CYC = RAMP_BASE_US * CLK_MHZ;
   localparam int PWM_WIN_CYC = 2048;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_REG_ONLY = 2'b00,
      MODE_PWM_ONLY = 2'b01,
      MODE_MUL_RAMP = 2'b10,
      MODE_RAMP_MUL = 2'b11
   } bbc_mode_type;
   typedef enum logic [1:0] {
      FREQ_250K = 2'b00,
      FREQ_500K = 2'b01,
      FREQ_1M = 2'b10
   } bbc_freq_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bbc_reg_req_type;
   typedef struct packed {
      bbc_freq_type freq;
      logic shift;
      logic min_ind;
      logic duty_limit;
   } bbc_boost_type;
   function automatic logic [10:0] bbc_mul(input logic [10:0] code,
                                          input logic [10:0] duty);
      logic [21:0] p;
      p = code * duty;
      return p[21:11]; // Truncated to 11 bits
   endfunction
endpackage

// >>> src/bbc_ramp.sv
// Ramp stepper: moves the output code one step per enable toward target
`timescale 1ns/1ps
`default_nettype none
module bbc_ramp
   import bbc_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic step_in,
   input wire logic [10:0] target_in,
   output logic [10:0] code_out,
   output logic busy_out
);
   logic [10:0] code_q;
   // ------------------------------------------------------------
   // One code step per step enable
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         code_q <= 11'h000;
      end else if (step_in) begin
         if (code_q < target_in) begin
            code_q <= code_q + 11'h001;
         end else if (code_q > target_in) begin
            code_q <= code_q - 11'h001;
         end
      end
   end
   assign code_out = code_q;
   assign busy_out = (code_q != target_in);
   a_ramp_single_step: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      !step_in |=> (code_q == $past(code_q)))
      else $error("ramp moved without step");
endmodule // bbc_ramp
`default_nettype wire

// >>> src/bbc_top.sv
// Backlight brightness and boost frequency control core
`timescale 1ns/1ps
`default_nettype none
module bbc_top
   import bbc_pkg::*;
#(
   parameter int RAMP_BASE_CYCLES = RAMP_BASE_CYC,
   parameter int PWM_WINDOW = PWM_WIN_CYC
)
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic pwm_in,
   output logic [10:0] brightness_code_out,
   output logic [1:0] boost_freq_out,
   output logic freq_shift_out,
   output logic min_inductor_out,
   output logic max_boost_duty_limit_out
);
   // Window length is tied to the 11-bit duty code, so only 2048 works
   if (RAMP_BASE_CYCLES < 1 || PWM_WINDOW != 2048) begin : g_bad_param
      $error("bbc_top: unsupported parameter values");
   end
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   bbc_reg_req_type req;
   logic [7:0] boost_config_q;
   logic [7:0] auto_high_q;
   logic [7:0] auto_low_q;
   logic [7:0] bright_low_q;
   logic [7:0] bright_high_q;
   logic [7:0] mode_reg_q;
   logic [7:0] ramp_reg_q;
   logic [10:0] brightness_code_q;
   logic [7:0] reg_rdata_q;
   assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in,
                  wdata: reg_wdata_in};
   // Plain storage writes
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boost_config_q <= RST_BOOST_CONFIG;
         auto_high_q <= RST_THRESH;
         auto_low_q <= RST_THRESH;
         bright_low_q <= RST_BRIGHT;
         bright_high_q <= RST_BRIGHT;
         mode_reg_q <= RST_MODE;
         ramp_reg_q <= RST_RAMP;
      end else if (req.wr) begin
         unique case (req.addr)
            OFS_BOOST_CONFIG: boost_config_q <= req.wdata;
            OFS_AUTO_HIGH: auto_high_q <= req.wdata;
            OFS_AUTO_LOW: auto_low_q <= req.wdata;
            OFS_BRIGHT_LOW: bright_low_q <= {5'h00, req.wdata[2:0]};
            OFS_BRIGHT_HIGH: bright_high_q <= req.wdata;
            OFS_BRIGHT_MODE: mode_reg_q <= {6'h00, req.wdata[1:0]};
            OFS_RAMP_CONFIG: ramp_reg_q <= {5'h00, req.wdata[2:0]};
            default: ;
         endcase
      end
   end
   // Set-point latched only by the high-byte write
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         brightness_code_q <= 11'h000;
      end else if (req.wr && req.addr == OFS_BRIGHT_HIGH) begin
         brightness_code_q <= {req.wdata, bright_low_q[2:0]};
      end
   end
   // ------------------------------------------------------------
   // PWM duty measurement
   // ------------------------------------------------------------
   logic pwm_s1_q;
   logic pwm_s2_q;
   logic [10:0] win_cnt_q;
   logic [11:0] high_cnt_q;
   logic [10:0] duty_q;
   // Two-flop synchroniser; the pin is asynchronous to clk_in
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwm_s1_q <= 1'b0;
         pwm_s2_q <= 1'b0;
      end else begin
         pwm_s1_q <= pwm_in;
         pwm_s2_q <= pwm_s1_q;
      end
   end
   // High-time count over a fixed window gives duty in 1/2048 units
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         win_cnt_q <= 11'h000;
         high_cnt_q <= 12'h000;
         duty_q <= 11'h000;
      end else begin
         win_cnt_q <= win_cnt_q + 11'h001;
         if (win_cnt_q == CODE_MAX) begin
            // Full window saturates to the top code
            if (high_cnt_q + {11'h000, pwm_s2_q} > 12'h7FF) begin
               duty_q <= CODE_MAX;
            end else begin
               duty_q <= high_cnt_q[10:0] + {10'h000, pwm_s2_q};
            end
            high_cnt_q <= 12'h000;
         end else begin
            high_cnt_q <= high_cnt_q + {11'h000, pwm_s2_q};
         end
      end
   end
   // ------------------------------------------------------------
   // Mode selection of ramp target and output combination
   // ------------------------------------------------------------
   bbc_mode_type mode;
   logic [10:0] ramp_target;
   logic [10:0] ramp_code;
   logic [10:0] final_code;
   assign mode = bbc_mode_type'(mode_reg_q[1:0]);
   always_comb begin
      unique case (mode)
         MODE_REG_ONLY: ramp_target = brightness_code_q;
         MODE_PWM_ONLY: ramp_target = duty_q;
         MODE_MUL_RAMP: ramp_target = bbc_mul(brightness_code_q, duty_q);
         MODE_RAMP_MUL: ramp_target = brightness_code_q;
      endcase
   end
   // Duty applied after the ramp in mode 11, so duty changes act at once
   always_comb begin
      if (mode == MODE_RAMP_MUL) begin
         final_code = bbc_mul(ramp_code, duty_q);
      end else begin
         final_code = ramp_code;
      end
   end
   // ------------------------------------------------------------
   // Ramp step timing: eight rates, one cycle at 0, base time doubling per setting from 1
   // ------------------------------------------------------------
   logic [31:0] step_cnt_q;
   logic [31:0] step_len;
   logic step_en;
   logic ramp_busy;
   assign step_len = (ramp_reg_q[2:0] == 3'h0) ? 32'h0000_0001 :
      32'(RAMP_BASE_CYCLES) << (ramp_reg_q[2:0] - 3'h1);
   assign step_en = (step_cnt_q + 32'h0000_0001 >= step_len);
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         step_cnt_q <= 32'h0000_0000;
      end else if (step_en || !ramp_busy) begin
         step_cnt_q <= 32'h0000_0000;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
   end
   bbc_ramp u_ramp (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .step_in(step_en && ramp_busy),
      .target_in(ramp_target),
      .code_out(ramp_code),
      .busy_out(ramp_busy)
   );
   // Output code registered
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         brightness_code_out <= 11'h000;
      end else begin
         brightness_code_out <= final_code;
      end
   end
   // ------------------------------------------------------------
   // Boost frequency selection
   // ------------------------------------------------------------
   logic auto_en;
   bbc_boost_type boost_d;
   bbc_boost_type boost_q;
   assign auto_en = (auto_high_q != 8'h00) || (auto_low_q != 8'h00);
   always_comb begin
      boost_d.shift = boost_config_q[BIT_FREQ_SHIFT];
      boost_d.min_ind = boost_config_q[BIT_MIN_IND];
      if (!auto_en) begin
         boost_d.freq = boost_config_q[BIT_FREQ_SEL] ? FREQ_1M : FREQ_500K;
      end else if (bright_high_q < auto_low_q) begin
         boost_d.freq = FREQ_250K;
      end else if (bright_high_q >= auto_high_q) begin
         boost_d.freq = FREQ_1M;
      end else begin
         boost_d.freq = FREQ_500K;
      end
      boost_d.duty_limit = (boost_d.freq == FREQ_250K);
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boost_q <= '{freq: FREQ_500K, shift: 1'b0, min_ind: 1'b0,
                      duty_limit: 1'b0};
      end else begin
         boost_q <= boost_d;
      end
   end
   assign boost_freq_out = boost_q.freq;
   assign freq_shift_out = boost_q.shift;
   assign min_inductor_out = boost_q.min_ind;
   assign max_boost_duty_limit_out = boost_q.duty_limit;
   // ------------------------------------------------------------
   // Register read-back, one cycle after the read strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_q <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            OFS_BOOST_CONFIG: reg_rdata_q <= boost_config_q;
            OFS_AUTO_HIGH: reg_rdata_q <= auto_high_q;
            OFS_AUTO_LOW: reg_rdata_q <= auto_low_q;
            OFS_BRIGHT_LOW: reg_rdata_q <= bright_low_q;
            OFS_BRIGHT_HIGH: reg_rdata_q <= bright_high_q;
            OFS_BRIGHT_MODE: reg_rdata_q <= mode_reg_q;
            OFS_RAMP_CONFIG: reg_rdata_q <= ramp_reg_q;
            OFS_STATUS: reg_rdata_q <= {3'h0, ramp_busy, auto_en,
                                        boost_q.duty_limit, boost_q.freq};
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end
   assign reg_rdata_out = reg_rdata_q;
   // ------------------------------------------------------------
   // Checks: register set-point and brightness path
   // ------------------------------------------------------------
   // High-byte write loads the whole code in one go
   a_code_on_msb: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (req.wr && req.addr == OFS_BRIGHT_HIGH) |=>
      brightness_code_q == {$past(req.wdata), $past(bright_low_q[2:0])})
      else $error("set-point not loaded by high-byte write");
   // Low-byte write alone must not disturb the LEDs
   a_low_no_apply: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (req.wr && req.addr == OFS_BRIGHT_LOW) |=> $stable(brightness_code_q))
      else $error("low-byte write changed set-point");
   // Only three low bits are kept
   a_low_bits_mask: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (req.wr && req.addr == OFS_BRIGHT_LOW) |=> bright_low_q[7:3] == 5'h00)
      else $error("low-byte register kept upper bits");
   // Duty code moves only at a window end
   a_duty_update: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      win_cnt_q != CODE_MAX |=> $stable(duty_q))
      else $error("duty changed outside window end");
   // Mode 00 target is the register code
   a_mode00_target: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mode == MODE_REG_ONLY |-> ramp_target == brightness_code_q)
      else $error("mode 00 target not register code");
   // Mode 01 target is the measured duty
   a_mode01_target: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mode == MODE_PWM_ONLY |-> ramp_target == duty_q)
      else $error("mode 01 target not duty");
   // Mode 10 ramps the product, not the raw code
   a_mode10_target: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mode == MODE_MUL_RAMP |->
      ramp_target == bbc_mul(brightness_code_q, duty_q))
      else $error("mode 10 target not product");
   // Outside mode 11 the output is the ramp output, one cycle late
   a_ramp_to_out: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mode != MODE_RAMP_MUL |=> brightness_code_out == $past(ramp_code))
      else $error("output not ramp output");
   // Mode 11 multiplies after the ramp
   a_mode11_mul: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      mode == MODE_RAMP_MUL |=>
      brightness_code_out == bbc_mul($past(ramp_code), $past(duty_q)))
      else $error("mode 11 output not ramp times duty");
   // Step timer counts while a ramp is pending and no step is due
   a_step_count: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (ramp_busy && !step_en) |=>
      step_cnt_q == $past(step_cnt_q) + 32'h0000_0001)
      else $error("step timer not counting");
   // ------------------------------------------------------------
   // Checks: boost frequency selection
   // ------------------------------------------------------------
   // Programmed frequency used while both thresholds are zero
   a_auto_off_freq: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !auto_en |=> boost_q.freq ==
      ($past(boost_config_q[BIT_FREQ_SEL]) ? FREQ_1M : FREQ_500K))
      else $error("programmed frequency not followed");
   // The low frequency always carries the duty limit
   a_250k_limit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      boost_q.freq == FREQ_250K |-> boost_q.duty_limit)
      else $error("250 kHz without duty limit");
   // And the limit never shows at the higher frequencies
   a_limit_only_250k: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      boost_q.duty_limit |-> boost_q.freq == FREQ_250K)
      else $error("duty limit outside 250 kHz");
   // Unused encoding must never leave the block
   a_freq_legal: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      boost_q.freq != 2'b11)
      else $error("illegal frequency code");
   // Below the low threshold: 250 kHz
   a_auto_low_band: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (auto_en && bright_high_q < auto_low_q) |=> boost_q.freq == FREQ_250K)
      else $error("auto low band wrong");
   // Between thresholds, low edge included: 500 kHz
   a_auto_mid_band: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (auto_en && bright_high_q >= auto_low_q && bright_high_q < auto_high_q)
      |=> boost_q.freq == FREQ_500K)
      else $error("auto middle band wrong");
   // At or above both thresholds: 1 MHz
   a_auto_high_band: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (auto_en && bright_high_q >= auto_low_q && bright_high_q >= auto_high_q)
      |=> boost_q.freq == FREQ_1M)
      else $error("auto high band wrong");
   // Shift and inductor bits are plain registered copies
   a_shift_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ##1 freq_shift_out == $past(boost_config_q[BIT_FREQ_SHIFT]))
      else $error("frequency shift not following bit 6");
   a_min_ind_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ##1 min_inductor_out == $past(boost_config_q[BIT_MIN_IND]))
      else $error("inductor bit not following bit 4");
endmodule // bbc_top
`default_nettype wire

// >>> tb/bbc_pwm_src.sv
// PWM source model driving the brightness control PWM pin
`timescale 1ns/1ps
`default_nettype none
module bbc_pwm_src (
   input wire logic clk_in,
   input wire logic en_in,
   input wire logic [7:0] period_in,
   input wire logic [7:0] high_in,
   output logic pwm_out
);
   logic [7:0] cnt_q;
   // Period counter; held at zero while the source is off
   always_ff @(posedge clk_in) begin
      if (!en_in || cnt_q >= period_in - 8'h01) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // High for the first high_in cycles of each period, low when off
   assign pwm_out = en_in && (cnt_q < high_in);
endmodule // bbc_pwm_src
`default_nettype wire

// >>> tb/bbc_top_tb.sv
// Self-checking testbench for the brightness and boost control core
`timescale 1ns/1ps
`default_nettype none
module bbc_top_tb
   import bbc_pkg::*;
;
   typedef struct packed {
      logic [7:0] cfg, hi, lo, msb;
      logic [1:0] freq;
      logic lim;
   } bbc_tb_row_type;
   logic clk_in = 1'b0, arst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic pwm_in, shift, min_ind, lim, pwm_en = 1'b0;
   logic [7:0] per = 8'h40, hi_t = 8'h40;
   logic [10:0] code;
   logic [1:0] freq;
   int fail_count = 0, compares = 0, chg = 0, cyc = 0;
   // Auto bands, programmed frequency, shift and inductor bit
   bbc_tb_row_type rows [10] = '{
      '{8'h00, 8'h00, 8'h00, 8'h80, 2'b01, 1'b0},
      '{8'h20, 8'h00, 8'h00, 8'h80, 2'b10, 1'b0},
      '{8'h60, 8'h00, 8'h00, 8'h80, 2'b10, 1'b0},
      '{8'h10, 8'h00, 8'h00, 8'h80, 2'b01, 1'b0},
      '{8'h00, 8'h80, 8'h40, 8'h3F, 2'b00, 1'b1},
      '{8'h00, 8'h80, 8'h40, 8'h40, 2'b01, 1'b0},
      '{8'h00, 8'h80, 8'h40, 8'h7F, 2'b01, 1'b0},
      '{8'h20, 8'h80, 8'h40, 8'h80, 2'b10, 1'b0},
      '{8'h00, 8'h00, 8'h40, 8'h3F, 2'b00, 1'b1},
      '{8'h20, 8'h80, 8'h00, 8'h10, 2'b01, 1'b0}};
   logic [7:0] rd_v;
   // ---------------------------------------------------------------
   // Clock, design and far-side model
   // ---------------------------------------------------------------
   always #5 clk_in = ~clk_in;
   bbc_top #(.RAMP_BASE_CYCLES(4), .PWM_WINDOW(2048)) u_bbc_top (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .pwm_in(pwm_in), .brightness_code_out(code),
      .boost_freq_out(freq), .freq_shift_out(shift),
      .min_inductor_out(min_ind), .max_boost_duty_limit_out(lim));
   bbc_pwm_src u_bbc_pwm_src (.clk_in(clk_in), .en_in(pwm_en),
      .period_in(per), .high_in(hi_t), .pwm_out(pwm_in));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp, input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   // Strobe held for exactly one sampling edge
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   // Waits for the code to settle near exp; chg counts code changes
   task automatic wait_code(input logic [11:0] exp, input int lim_c);
      int n;
      logic [10:0] prev;
      n = 0;
      chg = 0;
      prev = code;
      while (n < lim_c && !({1'b0, code} + 12'd2 >= exp
             && exp + 12'd2 >= {1'b0, code})) begin
         @(posedge clk_in);
         #1 n++;
         if (code !== prev) chg++;
         prev = code;
      end
      chk(n < lim_c, 1, "code did not settle");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard well above the longest PWM settle
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         $display("mismatch at %0t: timeout", $time);
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      #1 chk({freq, code, lim, shift, min_ind}, {2'b01, 14'h0}, "reset out");
      @(posedge clk_in);
      arst_n_in <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i].msb, rd_v);
         chk(rd_v, 8'h00, "reset value or unmapped read");
      end
      wr(OFS_AUTO_HIGH, 8'hA5);
      wr(8'h7E, 8'h55);
      rd(OFS_AUTO_HIGH, rd_v);
      chk(rd_v, 8'hA5, "readback");
      rd(8'h7E, rd_v);
      chk(rd_v, 8'h00, "unmapped write");
      foreach (rows[i]) begin
         wr(OFS_BOOST_CONFIG, rows[i].cfg);
         wr(OFS_AUTO_HIGH, rows[i].hi);
         wr(OFS_AUTO_LOW, rows[i].lo);
         wr(OFS_BRIGHT_HIGH, rows[i].msb);
         repeat (3) @(posedge clk_in);
         #1 chk(freq, rows[i].freq, "freq");
         chk(lim, rows[i].lim, "duty limit");
         chk({shift, min_ind}, {rows[i].cfg[6], rows[i].cfg[4]}, "cfg");
      end
      wr(OFS_AUTO_HIGH, 8'h00);
      wr(OFS_AUTO_LOW, 8'h00);
      // Register-only mode with a full-duty PWM that must be ignored
      pwm_en <= 1'b1;
      wr(OFS_BRIGHT_HIGH, 8'h00);
      wait_code(12'h000, 300);
      wr(OFS_BRIGHT_LOW, 8'h05);
      repeat (4) @(posedge clk_in);
      #1 chk(code, 11'h000, "low byte applied early");
      wr(OFS_BRIGHT_HIGH, 8'h10);
      wait_code(12'h085, 300);
      chk(chg > 100, 1, "register code not ramped");
      wr(OFS_RAMP_CONFIG, 8'h02);
      wr(OFS_BRIGHT_HIGH, 8'h11);
      repeat (40) @(posedge clk_in);
      #1 chk(code < 11'h08D, 1, "slow ramp too fast");
      wait_code(12'h08D, 60);
      wr(OFS_RAMP_CONFIG, 8'h00);
      // PWM-only, then both multiply orders
      hi_t <= 8'h20;
      wr(OFS_BRIGHT_MODE, 8'h01);
      wait_code(12'h400, 7000);
      wr(OFS_BRIGHT_LOW, 8'h00);
      wr(OFS_BRIGHT_HIGH, 8'h80);
      wr(OFS_BRIGHT_MODE, 8'h02);
      wait_code(12'h200, 4000);
      hi_t <= 8'h10;
      wait_code(12'h100, 5000);
      chk(chg > 100, 1, "product not ramped");
      wr(OFS_BRIGHT_MODE, 8'h03);
      // Let the output drop to ramp times duty before waiting on it
      repeat (2) @(posedge clk_in);
      wait_code(12'h100, 4000);
      hi_t <= 8'h20;
      wait_code(12'h200, 5000);
      chk(chg < 5, 1, "duty change ramped");
      wr(OFS_BRIGHT_HIGH, 8'hFF);
      wait_code(12'h3FC, 4000);
      chk(chg > 100, 1, "register change not ramped");
      summarize();
   end
endmodule // bbc_top_tb
`default_nettype wire
